// ===== rtl/rcds_defines.svh
// Constants for the reset cause and delay sequencer.
`ifndef RCDS_DEFINES_SVH
`define RCDS_DEFINES_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define RCDS_CLK_PERIOD_NS 10
`define RCDS_T_POR_NS      10000
`define RCDS_T_STARTUP_NS  20000
`define RCDS_T_PUP_NS      64000000
`define RCDS_T_RST_NS      20000
`define RCDS_T_LOCK_NS     20000
`define RCDS_T_MON_NS      100000
`define RCDS_CYC_MIN(t) (((t) + `RCDS_CLK_PERIOD_NS - 1) / `RCDS_CLK_PERIOD_NS)
`define RCDS_OSC_PERIODS   1024
`define RCDS_CNT_W         24

// ==========================================================================
// Reset cause flag layout
// ==========================================================================
`define RCDS_BIT_TRAP_CLASH 15
`define RCDS_BIT_BAD_INSTR  14
`define RCDS_BIT_REG_STBY   8
`define RCDS_BIT_PIN_RESET  7
`define RCDS_BIT_INSTR_RST  6
`define RCDS_BIT_DOG_SOFT   5
`define RCDS_BIT_DOG_TMO    4
`define RCDS_BIT_SLEEP      3
`define RCDS_BIT_IDLE       2
`define RCDS_BIT_BROWN      1
`define RCDS_BIT_POWER_ON   0
`define RCDS_FLAGS_IMPL     16'hc1ff
`define RCDS_FLAGS_RST      16'h0003
`define RCDS_CLKSEL_LSB     12

// ==========================================================================
// Register map and bus answers
// ==========================================================================
`define RCDS_AXI_AW      8
`define RCDS_ADDR_FLAGS  8'h00
`define RCDS_ADDR_CLKCTL 8'h04
`define RCDS_ADDR_STATUS 8'h08
`define RCDS_RESP_OKAY   2'h0
`define RCDS_RESP_SLVERR 2'h2

`endif

// ===== rtl/rcds_down_timer.sv
// Loadable down counter that flags when it has run out.
`timescale 1ns/1ns

module rcds_down_timer #(
  parameter int W = 24
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         step,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } rcds_tmr_t;

  rcds_tmr_t q;
  rcds_tmr_t d;

  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (step && (q.cnt != '0)) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = (q.cnt == '0);

endmodule

// ===== rtl/rcds_pkg.sv
// Types shared by the reset cause and delay sequencer.
`include "rcds_defines.svh"

package rcds_pkg;

  // ========================================================================
  // Sequencer and clock release phases
  // ========================================================================
  typedef enum logic [2:0] {
    RCDS_S_POR   = 3'h0,
    RCDS_S_START = 3'h1,
    RCDS_S_RST   = 3'h3,
    RCDS_S_RUN   = 3'h2,
    RCDS_S_WAKE  = 3'h6
  } rcds_seq_t;

  typedef enum logic [1:0] {
    RCDS_C_OSC   = 2'h0,
    RCDS_C_LOCK  = 2'h1,
    RCDS_C_READY = 2'h3
  } rcds_clk_t;

  // ========================================================================
  // State of the top module, apart from the counts in its delay timers
  // ========================================================================
  typedef struct packed {
    logic [3:0]              s1;
    logic [3:0]              s2;
    logic                    osc_prev;
    logic                    boot;
    rcds_seq_t               seq;
    rcds_clk_t               ck;
    logic                    lock_due;
    logic                    long_mon;
    logic                    mon_wait;
    logic                    mon_on;
    logic [2:0]              clk_sel;
    logic [15:0]             flags;
    logic                    sys_rst;
    logic                    clk_rel;
    logic                    dog_run;
    logic                    aw_have;
    logic                    w_have;
    logic [`RCDS_AXI_AW-1:0] aw_addr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
  } rcds_state_t;

endpackage

// ===== rtl/rcds_sequencer.sv
// Reset cause flags, clock source choice and reset release timing.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "rcds_defines.svh"

module rcds_sequencer
  import rcds_pkg::*;
#(
  parameter int PUP_CYCLES = `RCDS_CYC_MIN(`RCDS_T_PUP_NS),
  parameter int MON_CYCLES = `RCDS_CYC_MIN(`RCDS_T_MON_NS)
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    por_det,
  input  wire logic                    brown_det,
  input  wire logic                    master_clear_pin_n,
  input  wire logic                    osc_clk_pin,
  input  wire logic                    dog_timeout,
  input  wire logic                    reset_instr,
  input  wire logic                    bad_opcode,
  input  wire logic                    uninit_w_access,
  input  wire logic                    trap_clash,
  input  wire logic                    power_save_instruction,
  input  wire logic                    power_save_idle,
  input  wire logic                    wake_event,
  input  wire logic                    dog_enable_fuse,
  input  wire logic [2:0]              initial_clock_fuse_field,
  input  wire logic                    clock_switch_en,
  input  wire logic                    regulator_en,
  input  wire logic                    osc_crystal,
  input  wire logic                    osc_pll,
  output logic                         system_reset_signal,
  output logic                         sysclk_release,
  output logic                         clock_failure_monitor,
  output logic                         dog_run,
  output logic [2:0]                   current_clock_select,
  input  wire logic [`RCDS_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`RCDS_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);

  // ========================================================================
  // Delay counts
  // ========================================================================
  localparam logic [`RCDS_CNT_W-1:0] POR_CYC =
    `RCDS_CNT_W'(`RCDS_CYC_MIN(`RCDS_T_POR_NS));
  localparam logic [`RCDS_CNT_W-1:0] START_CYC =
    `RCDS_CNT_W'(`RCDS_CYC_MIN(`RCDS_T_STARTUP_NS));
  localparam logic [`RCDS_CNT_W-1:0] RST_CYC =
    `RCDS_CNT_W'(`RCDS_CYC_MIN(`RCDS_T_RST_NS));
  localparam logic [`RCDS_CNT_W-1:0] LOCK_CYC =
    `RCDS_CNT_W'(`RCDS_CYC_MIN(`RCDS_T_LOCK_NS));
  localparam logic [`RCDS_CNT_W-1:0] OSC_CNT = `RCDS_CNT_W'(`RCDS_OSC_PERIODS);
  localparam logic [`RCDS_CNT_W-1:0] PUP_CYC = `RCDS_CNT_W'(PUP_CYCLES);
  localparam logic [`RCDS_CNT_W-1:0] MON_CYC = `RCDS_CNT_W'(MON_CYCLES);

  rcds_state_t q;
  rcds_state_t d;

  logic                    seq_load;
  logic [`RCDS_CNT_W-1:0]  seq_val;
  logic                    seq_done;
  logic                    osc_load;
  logic [`RCDS_CNT_W-1:0]  osc_val;
  logic                    osc_done;
  logic                    osc_step;
  logic                    mon_load;
  logic                    mon_done;

  // ========================================================================
  // Delay timers
  // ========================================================================
  rcds_down_timer #(.W(`RCDS_CNT_W)) u_seq_tmr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (seq_load),
    .load_val (seq_val),
    .step     (1'b1),
    .done     (seq_done)
  );

  // The oscillator count steps on oscillator edges, the lock wait on aclk.
  assign osc_step = (q.ck == RCDS_C_OSC) ? (q.s2[3] & ~q.osc_prev) : 1'b1;

  rcds_down_timer #(.W(`RCDS_CNT_W)) u_osc_tmr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (osc_load),
    .load_val (osc_val),
    .step     (osc_step),
    .done     (osc_done)
  );

  rcds_down_timer #(.W(`RCDS_CNT_W)) u_mon_tmr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (mon_load),
    .load_val (MON_CYC),
    .step     (1'b1),
    .done     (mon_done)
  );

  // ========================================================================
  // Next state
  // ========================================================================
  always_comb begin
    logic        por;
    logic        cold;
    logic        warm;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic [15:0] fl;
    logic [31:0] rd;
    logic        wr_ok;
    por    = 1'b0;
    cold   = 1'b0;
    warm   = 1'b0;
    hw_set = '0;
    hw_clr = '0;
    fl     = q.flags;
    rd     = '0;
    wr_ok  = 1'b0;
    d      = q;
    seq_load = 1'b0;
    seq_val  = RST_CYC;
    osc_load = 1'b0;
    osc_val  = OSC_CNT;
    mon_load = 1'b0;

    // Pins pass two flops; only the second stage is ever looked at.
    d.s1 = {osc_clk_pin, master_clear_pin_n, brown_det, por_det};
    d.s2 = q.s1;
    d.osc_prev = q.s2[3];
    d.boot = 1'b0;

    // Leaving the block reset counts as a power-on event.
    por  = q.s2[0] | q.boot;
    cold = por | q.s2[1];
    warm = ~q.s2[2] | dog_timeout | reset_instr | bad_opcode
         | uninit_w_access | trap_clash;

    // ---------------- reset release sequence ----------------
    case (q.seq)
      RCDS_S_POR: begin
        if (seq_done) begin
          d.seq = RCDS_S_START;
          seq_load = 1'b1;
          seq_val = regulator_en ? START_CYC : PUP_CYC;
        end
      end
      RCDS_S_START: begin
        if (seq_done) begin
          d.seq = RCDS_S_RST;
          seq_load = 1'b1;
          seq_val = RST_CYC;
        end
      end
      RCDS_S_RST: begin
        if (seq_done) begin
          d.seq = RCDS_S_RUN;
        end
      end
      RCDS_S_RUN: begin
        if (wake_event && regulator_en) begin
          d.seq = RCDS_S_WAKE;
          seq_load = 1'b1;
          seq_val = START_CYC;
        end
      end
      RCDS_S_WAKE: begin
        if (seq_done) begin
          d.seq = RCDS_S_RUN;
        end
      end
      default: begin
        d.seq = RCDS_S_POR;
      end
    endcase

    // A level reset keeps reloading its first delay while it is held.
    if (cold) begin
      d.seq = RCDS_S_POR;
      seq_load = 1'b1;
      seq_val = POR_CYC;
    end else if (warm) begin
      d.seq = RCDS_S_RST;
      seq_load = 1'b1;
      seq_val = RST_CYC;
    end

    // ---------------- system clock release ----------------
    case (q.ck)
      RCDS_C_OSC: begin
        if (osc_done) begin
          if (q.lock_due) begin
            d.ck = RCDS_C_LOCK;
            osc_load = 1'b1;
            osc_val = LOCK_CYC;
          end else begin
            d.ck = RCDS_C_READY;
          end
        end
      end
      RCDS_C_LOCK: begin
        if (osc_done) begin
          d.ck = RCDS_C_READY;
        end
      end
      RCDS_C_READY: begin
        d.ck = RCDS_C_READY;
      end
      default: begin
        d.ck = RCDS_C_READY;
      end
    endcase

    // Clock waits start with a cold event only, alongside its reset delays; a warm reset leaves them running.
    if (cold) begin
      d.lock_due = osc_pll;
      osc_load = 1'b1;
      if (osc_crystal) begin
        d.ck = RCDS_C_OSC;
        osc_val = OSC_CNT;
      end else if (osc_pll) begin
        d.ck = RCDS_C_LOCK;
        osc_val = LOCK_CYC;
      end else begin
        d.ck = RCDS_C_READY;
      end
      d.long_mon = osc_crystal | osc_pll;
    end else if (warm) begin
      d.long_mon = 1'b0;
    end

    // ---------------- clock monitor start ----------------
    if (q.mon_wait && mon_done) begin
      d.mon_wait = 1'b0;
      d.mon_on = 1'b1;
    end
    if ((q.seq == RCDS_S_RST) && (d.seq == RCDS_S_RUN)) begin
      if (q.long_mon) begin
        d.mon_wait = 1'b1;
        mon_load = 1'b1;
      end else begin
        d.mon_on = 1'b1;
      end
    end
    if (d.seq inside {RCDS_S_POR, RCDS_S_START, RCDS_S_RST}) begin
      d.mon_wait = 1'b0;
      d.mon_on = 1'b0;
    end

    // ---------------- clock source selection ----------------
    if (cold || (warm && !clock_switch_en)) begin
      d.clk_sel = initial_clock_fuse_field;
    end

    // ---------------- register bus ----------------
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      wr_ok = d.aw_addr inside {`RCDS_ADDR_FLAGS, `RCDS_ADDR_CLKCTL, `RCDS_ADDR_STATUS};
      d.bresp = wr_ok ? `RCDS_RESP_OKAY : `RCDS_RESP_SLVERR;
      // Only the flag word stores anything; nothing here starts a reset.
      if (d.aw_addr == `RCDS_ADDR_FLAGS) begin
        if (d.wstrb[0]) begin
          fl[7:0] = d.wdata[7:0];
        end
        if (d.wstrb[1]) begin
          fl[15:8] = d.wdata[15:8];
        end
      end
    end
    d.awready = ~d.aw_have & ~d.bvalid;
    d.wready = ~d.w_have & ~d.bvalid;

    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = `RCDS_RESP_OKAY;
      case (s_axi_araddr)
        `RCDS_ADDR_FLAGS: rd[15:0] = q.flags;
        `RCDS_ADDR_CLKCTL: rd[`RCDS_CLKSEL_LSB +: 3] = q.clk_sel;
        `RCDS_ADDR_STATUS: rd[8:0] = {q.seq, q.ck, q.mon_on, q.dog_run, q.clk_rel, q.sys_rst};
        default: d.rresp = `RCDS_RESP_SLVERR;
      endcase
      d.rdata = rd;
    end
    d.arready = ~d.rvalid;

    // ---------------- reset cause flags ----------------
    if (cold) begin
      hw_clr[`RCDS_BIT_TRAP_CLASH] = 1'b1;
      hw_clr[`RCDS_BIT_BAD_INSTR] = 1'b1;
      hw_clr[`RCDS_BIT_INSTR_RST] = 1'b1;
      hw_clr[`RCDS_BIT_DOG_TMO] = 1'b1;
      hw_clr[`RCDS_BIT_SLEEP] = 1'b1;
      hw_clr[`RCDS_BIT_IDLE] = 1'b1;
      hw_set[`RCDS_BIT_BROWN] = 1'b1;
    end
    if (por) begin
      hw_clr = ~(16'h0001 << `RCDS_BIT_POWER_ON);
      hw_set[`RCDS_BIT_POWER_ON] = 1'b1;
    end
    if (power_save_instruction) begin
      hw_clr[`RCDS_BIT_DOG_TMO] = 1'b1;
      hw_set[`RCDS_BIT_IDLE] = power_save_idle;
      hw_set[`RCDS_BIT_SLEEP] = ~power_save_idle;
    end
    hw_set[`RCDS_BIT_PIN_RESET] = ~q.s2[2];
    hw_set[`RCDS_BIT_DOG_TMO] = dog_timeout;
    hw_set[`RCDS_BIT_INSTR_RST] = reset_instr;
    hw_set[`RCDS_BIT_BAD_INSTR] = bad_opcode | uninit_w_access;
    hw_set[`RCDS_BIT_TRAP_CLASH] = trap_clash;
    // A hardware event beats a clear arriving in the same cycle.
    d.flags = ((fl & ~hw_clr) | hw_set) & `RCDS_FLAGS_IMPL;

    // ---------------- outputs ----------------
    d.sys_rst = d.seq inside {RCDS_S_POR, RCDS_S_START, RCDS_S_RST};
    d.clk_rel = (d.ck == RCDS_C_READY) && (d.seq != RCDS_S_WAKE);
    d.dog_run = dog_enable_fuse | d.flags[`RCDS_BIT_DOG_SOFT];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.boot <= 1'b1;
      // The pin idles high; starting its stages low would fake a pin reset.
      q.s1 <= 4'h4;
      q.s2 <= 4'h4;
      q.sys_rst <= 1'b1;
      q.flags <= `RCDS_FLAGS_RST;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign system_reset_signal = q.sys_rst;
  assign sysclk_release = q.clk_rel;
  assign clock_failure_monitor = q.mon_on;
  assign dog_run = q.dog_run;
  assign current_clock_select = q.clk_sel;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;

endmodule

// ===== verif/rcds_chk.sv
// Checker for the reset sequencer, bound onto its ports.
`timescale 1ns/1ns

module rcds_chk #(
  parameter int MON_CYCLES = 40
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       bad_opcode,
  input wire logic       trap_clash,
  input wire logic       master_clear_pin_n,
  input wire logic       dog_enable_fuse,
  input wire logic [2:0] initial_clock_fuse_field,
  input wire logic       clock_switch_en,
  input wire logic       osc_crystal,
  input wire logic       osc_pll,
  input wire logic       system_reset_signal,
  input wire logic       sysclk_release,
  input wire logic       clock_failure_monitor,
  input wire logic       dog_run,
  input wire logic [2:0] current_clock_select,
  input wire logic       s_axi_bvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ======================================
  // Phase counters
  // ======================================
  logic [31:0] hi_q, lo_q, rel_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= 32'h0;
      lo_q <= 32'h0;
      rel_q <= 32'h0;
    end else begin
      hi_q <= system_reset_signal ? hi_q + 32'h1 : 32'h0;
      lo_q <= system_reset_signal ? 32'h0 : lo_q + 32'h1;
      rel_q <= system_reset_signal ? hi_q : rel_q;
    end
  end

  // ======================================
  // Assertions
  // ======================================
  AST_BAD_RST:
    assert property (bad_opcode |-> ##[1:4] system_reset_signal)
    else $error("bad opcode gave no reset");
  AST_TRAP_RST:
    assert property (trap_clash |-> ##[1:4] system_reset_signal)
    else $error("trap clash gave no reset");
  AST_PIN_RST:
    assert property ($fell(master_clear_pin_n) |-> ##[2:6] system_reset_signal)
    else $error("pin gave no reset");
  AST_RST_HOLD:
    assert property ($fell(system_reset_signal) |-> hi_q >= 32'd2000)
    else $error("system reset too short");
  AST_MON_WAIT:
    assert property ($rose(clock_failure_monitor) && (osc_crystal || osc_pll)
      && rel_q >= 32'd3000 |-> lo_q >= 32'(MON_CYCLES - 1))
    else $error("monitor started early");
  AST_MON_REL:
    assert property ($rose(clock_failure_monitor) |-> !system_reset_signal)
    else $error("monitor started in reset");
  AST_DOG_FUSE:
    assert property (dog_enable_fuse && $past(dog_enable_fuse, 2) && $past(aresetn, 2)
      |-> dog_run)
    else $error("watchdog stopped with fuse set");
  AST_CLK_FUSE:
    assert property ($fell(system_reset_signal) && !clock_switch_en
      |-> current_clock_select == initial_clock_fuse_field)
    else $error("clock select not from fuses");
  AST_SW_NO_RST:
    assert property ($rose(s_axi_bvalid) && !system_reset_signal |-> !system_reset_signal [*4])
    else $error("register write caused reset");

  cover property ($fell(system_reset_signal));
  cover property ($rose(sysclk_release));
  cover property ($rose(clock_failure_monitor));
endmodule

bind rcds_sequencer rcds_chk #(.MON_CYCLES(MON_CYCLES)) u_rcds_chk (
  .aclk, .aresetn, .bad_opcode, .trap_clash, .master_clear_pin_n, .dog_enable_fuse,
  .initial_clock_fuse_field, .clock_switch_en, .osc_crystal, .osc_pll,
  .system_reset_signal, .sysclk_release, .clock_failure_monitor, .dog_run,
  .current_clock_select, .s_axi_bvalid
);

// ===== verif/tb_top.sv
// Self-checking bench for the reset sequencer.
`timescale 1ns/1ns
`include "rcds_defines.svh"

module tb_top;
  // ======================================
  // Signals
  // ======================================
  logic                    aclk, aresetn, por_det, brown_det, master_clear_pin_n, osc_clk_pin;
  logic                    dog_timeout, reset_instr, bad_opcode, uninit_w_access, trap_clash;
  logic                    power_save_instruction, power_save_idle, wake_event;
  logic                    dog_enable_fuse, clock_switch_en, regulator_en, osc_crystal, osc_pll;
  logic                    system_reset_signal, sysclk_release, clock_failure_monitor, dog_run;
  logic [2:0]              initial_clock_fuse_field, current_clock_select;
  logic [`RCDS_AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp, rs;
  logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  int                      fails, checked, n;

  rcds_sequencer #(.PUP_CYCLES(50), .MON_CYCLES(40)) u_rcds_sequencer (
    .aclk, .aresetn, .por_det, .brown_det, .master_clear_pin_n, .osc_clk_pin, .dog_timeout,
    .reset_instr, .bad_opcode, .uninit_w_access, .trap_clash, .power_save_instruction,
    .power_save_idle, .wake_event, .dog_enable_fuse, .initial_clock_fuse_field,
    .clock_switch_en, .regulator_en, .osc_crystal, .osc_pll, .system_reset_signal,
    .sysclk_release, .clock_failure_monitor, .dog_run, .current_clock_select,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // The raw oscillator runs free with a rising edge every six bus clocks.
  initial begin
    osc_clk_pin = 1'b0;
    forever #30 osc_clk_pin = ~osc_clk_pin;
  end

  // ======================================
  // Common tasks
  // ======================================
  task conclude();
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task tmo();
    fails++;
    conclude();
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid || s_axi_wvalid) && k < 200);
    while (s_axi_bvalid !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (k >= 200) tmo();
  endtask

  task automatic axr(input logic [7:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (s_axi_arready !== 1'b1 && k < 200);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      k++;
    end while (s_axi_rvalid !== 1'b1 && k < 200);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (k >= 200) tmo();
  endtask

  // Waits for the system reset to rise, then counts the cycles it stays high.
  task automatic wrst();
    int k;
    k = 0;
    while (system_reset_signal !== 1'b1 && k < 20) begin
      @(posedge aclk);
      k++;
    end
    n = 0;
    while (system_reset_signal !== 1'b0 && n < 9000) begin
      @(posedge aclk);
      n++;
    end
    if (k >= 20 || n >= 9000) tmo();
  endtask

  // ======================================
  // Scenarios
  // ======================================
  task t_boot();
    aresetn <= 1'b1;
    @(posedge aclk);
    wrst();
    rng(n, 4995, 5040);
    chk(32'(sysclk_release), 32'h0);
    chk(32'(clock_failure_monitor), 32'h0);
    chk(32'(current_clock_select), 32'h3);
    while (sysclk_release !== 1'b1 && n < 9000) begin
      @(posedge aclk);
      n++;
    end
    rng(n, 6100, 6260);
    chk(32'(clock_failure_monitor), 32'h1);
    axr(`RCDS_ADDR_FLAGS);
    chk(rd, 32'h3);
  endtask

  task t_sw();
    axw(`RCDS_ADDR_FLAGS, 32'hffff);
    axr(`RCDS_ADDR_FLAGS);
    chk(rd, 32'hc1ff);
    chk(32'(system_reset_signal), 32'h0);
    chk(32'(dog_run), 32'h1);
    axw(`RCDS_ADDR_FLAGS, 32'h0);
    axr(`RCDS_ADDR_FLAGS);
    chk(rd, 32'h0);
    chk(32'(dog_run), 32'h0);
    dog_enable_fuse <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(dog_run), 32'h1);
    dog_enable_fuse <= 1'b0;
  endtask

  task automatic t_warm();
    int pos [4] = '{`RCDS_BIT_BAD_INSTR, `RCDS_BIT_TRAP_CLASH, `RCDS_BIT_INSTR_RST,
                    `RCDS_BIT_DOG_TMO};
    for (int i = 0; i < 4; i++) begin
      repeat (5) @(posedge aclk);
      {dog_timeout, reset_instr, trap_clash, bad_opcode} <= 4'h1 << i;
      @(posedge aclk);
      {dog_timeout, reset_instr, trap_clash, bad_opcode} <= 4'h0;
      wrst();
      rng(n, 2000, 2015);
      axr(`RCDS_ADDR_FLAGS);
      chk(rd, 32'h1 << pos[i]);
      axw(`RCDS_ADDR_FLAGS, 32'h0);
    end
  endtask

  task t_psave();
    axw(`RCDS_ADDR_FLAGS, 32'h10);
    for (int i = 0; i < 2; i++) begin
      power_save_idle <= (i == 0);
      power_save_instruction <= 1'b1;
      @(posedge aclk);
      power_save_instruction <= 1'b0;
      repeat (4) @(posedge aclk);
      axr(`RCDS_ADDR_FLAGS);
      chk(rd, (i == 0) ? 32'h4 : 32'hc);
    end
  endtask

  task t_wake();
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({30'h0, sysclk_release, system_reset_signal}, 32'h0);
    repeat (2005) @(posedge aclk);
    chk(32'(sysclk_release), 32'h1);
  endtask

  // Brown-out, pin, brown-out, power-on, with clock switching enabled.
  task automatic t_cold();
    logic [2:0]  fz [4] = '{3'h5, 3'h2, 3'h2, 3'h2};
    logic [2:0]  sz [4] = '{3'h5, 3'h5, 3'h2, 3'h2};
    logic [31:0] fl [4] = '{32'h2, 32'h82, 32'h82, 32'h3};
    clock_switch_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      initial_clock_fuse_field <= fz[i];
      master_clear_pin_n <= (i != 1);
      por_det <= (i == 3);
      brown_det <= (i == 0 || i == 2);
      repeat (5) @(posedge aclk);
      {por_det, brown_det, master_clear_pin_n} <= 3'h1;
      wrst();
      chk(32'(current_clock_select), 32'(sz[i]));
      axr(`RCDS_ADDR_FLAGS);
      chk(rd, fl[i]);
    end
  endtask

  task t_bus();
    axr(8'h0c);
    chk({30'h0, rs}, {30'h0, `RCDS_RESP_SLVERR});
    chk(rd, 32'h0);
    axw(8'h0c, 32'hffff);
    chk({30'h0, rs}, {30'h0, `RCDS_RESP_SLVERR});
    axw(`RCDS_ADDR_CLKCTL, 32'h0);
    chk({30'h0, rs}, {30'h0, `RCDS_RESP_OKAY});
    axr(`RCDS_ADDR_CLKCTL);
    chk(32'(rd[14:12]), 32'h2);
  endtask

  // ======================================
  // Main sequence
  // ======================================
  initial begin
    fails = 0;
    checked = 0;
    {aresetn, por_det, brown_det, dog_timeout, reset_instr, bad_opcode} = 6'h0;
    {uninit_w_access, trap_clash, power_save_instruction, power_save_idle} = 4'h0;
    {wake_event, dog_enable_fuse, clock_switch_en, osc_pll} = 4'h0;
    {master_clear_pin_n, regulator_en, osc_crystal} = 3'h7;
    initial_clock_fuse_field = 3'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    t_boot();
    t_sw();
    t_warm();
    t_psave();
    t_wake();
    t_cold();
    t_bus();
    conclude();
  end
endmodule
